// ==== verilog/host_serial_timing_events.sv ====
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
//
// Functional notes
// - Idle gap between characters, 0 to 99 ms
// - Zero gap sends characters back to back
// - Resend message when no ACK/NAK arrives
// - Response time-out 0.0-9.9 s, 0.1 s steps
// - Host holds send right: wait, then error
// - Receive gap too long: discard, flag error
// - Character time-out 0.01-0.99 s steps
// - Decode event sends code 01h if enabled
// - Boot event code 03h: its enable resets to 0, so never sent
// - Parameter events use 07h, 08h, 0Ah
// - Each event class has own enable, except 0Ah
// - Defaults restore enables parameter events; an APB write in the same cycle blocks it
// - At most two resends, then transmit error
// - Raw decode data skips ACK/NAK
// - One or two stop bits, codes 01h/02h
module host_serial_timing_events
    import serial_timing_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Character transmitter handshake
    input wire logic tx_char_done,
    output logic tx_char_go,
    output logic tx_two_stop,
    // Message and link events
    input wire logic msg_start,
    input wire logic msg_raw,
    input wire logic msg_char_pending,
    input wire logic ack_rx,
    input wire logic nak_rx,
    input wire logic host_has_send,
    input wire logic rx_char,
    input wire logic rx_msg_end,
    output logic rx_discard,
    output logic resend_req,
    // Decoder events
    input wire logic decode_ok,
    input wire logic param_err,
    input wire logic param_stored,
    input wire logic defaults_set,
    output logic event_valid,
    output logic [7:0] event_code,
    input wire logic event_ready,
    // Interrupt
    output logic irq
);
    // Settings
    logic [7:0] stop_code; // Stop-bit setting code
    logic ackn_en; // ACK/NAK handshaking on
    logic [6:0] gap_ms; // Inter-character gap
    logic [6:0] resp_tenths; // Response time-out, 0.1 s units
    logic [6:0] char_hund; // Character time-out, 0.01 s units
    logic [2:0] ev_en; // Event enables: decode, boot, param
    logic [ST_W-1:0] status; // Sticky events
    logic [ST_W-1:0] irq_en; // Interrupt enables
    logic [ST_W-1:0] set_bits; // Events this cycle
    logic apb_wr; // Write access phase
    logic booted; // First enabled cycle after reset has passed

    ms_timer_if tmr();
    assign tmr.ce = clk_en;

    // Millisecond tick for every timer
    ms_tick_gen u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tmr(tmr)
    );

    // Gap timer
    logic gap_start, gap_busy, gap_exp;
    ms_countdown #(.W(7)) u_gap (
        .pclk(pclk),
        .presetn(presetn),
        .tmr(tmr),
        .start(gap_start),
        .load_ms(gap_ms),
        .busy(gap_busy),
        .expired()
    );
    assign gap_exp = !gap_busy;

    // Response timer, shared by ACK wait and contention wait
    logic resp_start, resp_busy, resp_exp;
    logic [13:0] resp_ms;
    assign resp_ms = 14'(resp_tenths * RESP_MS_PER_STEP);
    ms_countdown #(.W(14)) u_resp (
        .pclk(pclk),
        .presetn(presetn),
        .tmr(tmr),
        .start(resp_start),
        .load_ms(resp_ms),
        .busy(resp_busy),
        .expired(resp_exp)
    );

    // Receive character timer
    logic chr_start, chr_busy, chr_exp;
    logic [9:0] chr_ms;
    assign chr_ms = 10'(char_hund * CHAR_MS_PER_STEP);
    ms_countdown #(.W(10)) u_chr (
        .pclk(pclk),
        .presetn(presetn),
        .tmr(tmr),
        .start(chr_start),
        .load_ms(chr_ms),
        .busy(chr_busy),
        .expired(chr_exp)
    );

    // APB: zero wait states, unmapped reads zero, no error
    assign apb_wr = psel && penable && pwrite && clk_en;

    // Register writes, out-of-range values ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_code <= RST_STOP;
            ackn_en <= 1'b0;
            gap_ms <= RST_GAP;
            resp_tenths <= RST_RESP;
            char_hund <= RST_CHAR;
            ev_en <= RST_EVEN;
            irq_en <= '0;
        end else if (apb_wr) begin
            unique case (paddr)
                OFS_CTRL: begin
                    // Only 01h/02h accepted
                    if (pwdata[7:0] == CODE_ONE_STOP ||
                        pwdata[7:0] == CODE_TWO_STOP)
                        stop_code <= pwdata[7:0];
                    ackn_en <= pwdata[8];
                end
                OFS_GAP: if (pwdata <= 32'(GAP_MAX_MS))
                    gap_ms <= pwdata[6:0];
                OFS_RESP: if (pwdata <= 32'(RESP_MAX_TENTHS))
                    resp_tenths <= pwdata[6:0];
                OFS_CHAR: if (pwdata >= 32'(CHAR_MIN_HUNDREDTHS) &&
                              pwdata <= 32'(CHAR_MAX_HUNDREDTHS))
                    char_hund <= pwdata[6:0];
                OFS_EVEN: ev_en <= pwdata[2:0];
                OFS_IRQ_EN: irq_en <= pwdata[ST_W-1:0];
                default: ;
            endcase
            // Defaults restore re-enables parameter events unless an APB write takes the same cycle
        end else if (clk_en && defaults_set) begin
            ev_en[2] <= 1'b1;
        end
    end

    // Register reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_CTRL: prdata <= {23'h0, ackn_en, stop_code};
                OFS_GAP: prdata <= {25'h0, gap_ms};
                OFS_RESP: prdata <= {25'h0, resp_tenths};
                OFS_CHAR: prdata <= {25'h0, char_hund};
                OFS_EVEN: prdata <= {29'h0, ev_en};
                OFS_STATUS: prdata <= {27'h0, status};
                OFS_IRQ_EN: prdata <= {27'h0, irq_en};
                OFS_STATE: prdata <= {29'h0, resp_busy, gap_busy,
                    chr_busy};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Always ready, never error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
        end
    end

    // Transmit sequencing
    typedef enum logic [2:0] {
        TX_IDLE, TX_CONTEND, TX_CHARS, TX_SEND, TX_GAP, TX_WAIT_ACK
    } tx_state_type;
    tx_state_type tx_state;
    logic [1:0] resends; // Resends done for this message
    logic msg_hs; // Message uses ACK/NAK
    logic go_pulse;

    // Message state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
            resends <= 2'h0;
            msg_hs <= 1'b0;
            tx_char_go <= 1'b0;
            resend_req <= 1'b0;
        end else if (clk_en) begin
            tx_char_go <= 1'b0;
            resend_req <= 1'b0;
            unique case (tx_state)
                TX_IDLE: if (msg_start) begin
                    resends <= 2'h0;
                    // Raw decode data skips handshake
                    msg_hs <= ackn_en && !msg_raw;
                    // Host owns the line: wait it out
                    tx_state <= host_has_send ? TX_CONTEND : TX_CHARS;
                end
                TX_CONTEND: if (!host_has_send) begin
                    tx_state <= TX_CHARS;
                end else if (resp_exp) begin
                    tx_state <= TX_IDLE;
                end
                TX_CHARS: if (msg_char_pending && !tx_char_go) begin
                    tx_char_go <= 1'b1;
                    tx_state <= TX_SEND;
                end else if (!msg_char_pending) begin
                    tx_state <= msg_hs ? TX_WAIT_ACK : TX_IDLE;
                end
                // Gap only between characters, not after the last
                TX_SEND: if (tx_char_done) begin
                    tx_state <= msg_char_pending ? TX_GAP : TX_CHARS;
                end
                // Zero gap means next character at once
                TX_GAP: if (gap_exp) begin
                    tx_state <= TX_CHARS;
                end
                TX_WAIT_ACK: if (ack_rx) begin
                    tx_state <= TX_IDLE;
                end else if (nak_rx || resp_exp) begin
                    if (resends == 2'(MAX_RESENDS)) begin
                        tx_state <= TX_IDLE;
                    end else begin
                        resends <= resends + 2'h1;
                        resend_req <= 1'b1;
                        tx_state <= TX_GAP; // Source restores its count
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Gap starts when a character finishes and another is pending
    assign gap_start = (tx_state == TX_SEND) && tx_char_done &&
        msg_char_pending;
    // Response timer restarts on entering either wait
    assign resp_start = clk_en &&
        ((tx_state == TX_IDLE && msg_start && host_has_send) ||
         (tx_state == TX_CHARS && !msg_char_pending && msg_hs));

    // Stop bits follow the setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_two_stop <= 1'b0;
        end else if (clk_en) begin
            tx_two_stop <= (stop_code == CODE_TWO_STOP);
        end
    end

    // Receive character timing
    logic rx_active;
    assign chr_start = clk_en && rx_char;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_active <= 1'b0;
            rx_discard <= 1'b0;
        end else if (clk_en) begin
            rx_discard <= 1'b0;
            if (rx_char) begin
                rx_active <= 1'b1;
            end else if (rx_msg_end) begin
                rx_active <= 1'b0;
            end else if (rx_active && chr_exp) begin
                rx_active <= 1'b0;
                rx_discard <= 1'b1;
            end
        end
    end

    // Event message source, one pending code at a time
    logic [4:0] ev_pend; // Decode, boot, err, stored, defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_pend <= 5'h00;
            booted <= 1'b0;
            event_valid <= 1'b0;
            event_code <= 8'h00;
        end else if (clk_en) begin
            booted <= 1'b1;
            // Queue only enabled classes; defaults event always queued
            if (decode_ok && ev_en[0]) ev_pend[0] <= 1'b1;
            if (!booted && ev_en[1]) ev_pend[1] <= 1'b1;
            if (param_err && ev_en[2]) ev_pend[2] <= 1'b1;
            if (param_stored && ev_en[2]) ev_pend[3] <= 1'b1;
            if (defaults_set) ev_pend[4] <= 1'b1;
            if (event_valid && event_ready) begin
                event_valid <= 1'b0;
            end else if (!event_valid) begin
                event_valid <= 1'b1;
                if (ev_pend[1]) begin
                    event_code <= EV_BOOT;
                    ev_pend[1] <= 1'b0;
                end else if (ev_pend[0]) begin
                    event_code <= EV_DECODE;
                    ev_pend[0] <= decode_ok && ev_en[0];
                end else if (ev_pend[2]) begin
                    event_code <= EV_PARAM_ERR;
                    ev_pend[2] <= param_err && ev_en[2];
                end else if (ev_pend[3]) begin
                    event_code <= EV_PARAM_STORED;
                    ev_pend[3] <= param_stored && ev_en[2];
                end else if (ev_pend[4]) begin
                    event_code <= EV_DEFAULTS;
                    ev_pend[4] <= defaults_set;
                end else begin
                    event_valid <= 1'b0;
                end
            end
        end
    end

    // Sticky status, set wins over clear
    assign set_bits[ST_TX_ERR] = clk_en && tx_state == TX_WAIT_ACK &&
        !ack_rx && (nak_rx || resp_exp) &&
        resends == 2'(MAX_RESENDS);
    assign set_bits[ST_CONTEND_ERR] = clk_en &&
        tx_state == TX_CONTEND && host_has_send && resp_exp;
    assign set_bits[ST_RX_ERR] = clk_en && rx_active && !rx_char &&
        !rx_msg_end && chr_exp;
    assign set_bits[ST_TX_DONE] = clk_en && tx_state == TX_WAIT_ACK &&
        ack_rx;
    assign set_bits[ST_EVENT_SENT] = clk_en && event_valid &&
        event_ready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else begin
            status <= (apb_wr && paddr == OFS_IRQ_CLR) ?
                ((status & ~pwdata[ST_W-1:0]) | set_bits) :
                (status | set_bits);
        end
    end

    // Interrupt level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(status & irq_en);
        end
    end

    // Checks
    AST_TXERR_AFTER_TWO: assert property (@(posedge pclk)
        disable iff (!presetn) set_bits[ST_TX_ERR] |=>
        status[ST_TX_ERR] && tx_state == TX_IDLE)
        else $error("transmit error not flagged");
    AST_RESEND_LIMIT: assert property (@(posedge pclk)
        disable iff (!presetn) resend_req |-> resends <= 2'(MAX_RESENDS))
        else $error("too many resends");
    AST_RX_DISCARD: assert property (@(posedge pclk)
        disable iff (!presetn) set_bits[ST_RX_ERR] |=> rx_discard)
        else $error("receive timeout without discard");
    AST_STOP_BITS: assert property (@(posedge pclk)
        disable iff (!presetn) clk_en && stop_code == CODE_TWO_STOP
        |=> tx_two_stop)
        else $error("stop bit setting ignored");
    AST_DECODE_CODE: assert property (@(posedge pclk)
        disable iff (!presetn) $rose(event_valid) &&
        event_code == EV_DECODE |-> $past(ev_pend[0]))
        else $error("decode event without cause");
    AST_BOOT_ONCE: assert property (@(posedge pclk)
        disable iff (!presetn) booted |=> booted)
        else $error("boot flag lost");
    AST_CONTEND_ERR: assert property (@(posedge pclk)
        disable iff (!presetn) set_bits[ST_CONTEND_ERR] |=>
        status[ST_CONTEND_ERR])
        else $error("contention error not latched");
    AST_RAW_NO_ACK: assert property (@(posedge pclk)
        disable iff (!presetn) tx_state == TX_IDLE && msg_start &&
        msg_raw && clk_en |=> !msg_hs)
        else $error("raw data handshaked");
    AST_GAP_RANGE: assert property (@(posedge pclk)
        disable iff (!presetn) gap_ms <= 7'(GAP_MAX_MS))
        else $error("gap out of range");
endmodule : host_serial_timing_events
`default_nettype wire

// ==== verilog/serial_timing_pkg.sv ====
package serial_timing_pkg;
    // Clock and tick
    localparam int CLK_HZ = 40000000;
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 25;
    localparam int CYCLES_PER_MS = MS_NS / CLK_NS;
    // Setting ranges, in their own units
    localparam int GAP_MAX_MS = 99;
    localparam int RESP_MAX_TENTHS = 99;
    localparam int RESP_MS_PER_STEP = 100;
    localparam int CHAR_MIN_HUNDREDTHS = 1;
    localparam int CHAR_MAX_HUNDREDTHS = 99;
    localparam int CHAR_MS_PER_STEP = 10;
    localparam int MAX_RESENDS = 2;
    // Setting codes
    localparam logic [7:0] CODE_ENABLE = 8'h01;
    localparam logic [7:0] CODE_DISABLE = 8'h00;
    localparam logic [7:0] CODE_ONE_STOP = 8'h01;
    localparam logic [7:0] CODE_TWO_STOP = 8'h02;
    // Event codes
    localparam logic [7:0] EV_DECODE = 8'h01;
    localparam logic [7:0] EV_BOOT = 8'h03;
    localparam logic [7:0] EV_PARAM_ERR = 8'h07;
    localparam logic [7:0] EV_PARAM_STORED = 8'h08;
    localparam logic [7:0] EV_DEFAULTS = 8'h0A;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_GAP = 12'h004;
    localparam logic [11:0] OFS_RESP = 12'h008;
    localparam logic [11:0] OFS_CHAR = 12'h00C;
    localparam logic [11:0] OFS_EVEN = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    localparam logic [11:0] OFS_IRQ_EN = 12'h018;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h01C;
    localparam logic [11:0] OFS_STATE = 12'h020;
    localparam logic [11:0] OFS_CMD = 12'h024;
    // Reset values
    localparam logic [7:0] RST_STOP = 8'h01;
    localparam logic [6:0] RST_GAP = 7'h00;
    localparam logic [6:0] RST_RESP = 7'h14;
    localparam logic [6:0] RST_CHAR = 7'h19;
    localparam logic [2:0] RST_EVEN = 3'h4;
    // Status bits
    localparam int ST_TX_ERR = 0;
    localparam int ST_CONTEND_ERR = 1;
    localparam int ST_RX_ERR = 2;
    localparam int ST_TX_DONE = 3;
    localparam int ST_EVENT_SENT = 4;
    localparam int ST_W = 5;
endpackage : serial_timing_pkg

// ==== verilog/ms_timer_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Shared millisecond tick and enable between timing parts
interface ms_timer_if;
    logic ce; // Global clock enable
    logic tick; // One-cycle pulse each millisecond
    modport source (input ce, output tick);
    modport sink (input ce, input tick);
endinterface : ms_timer_if
`default_nettype wire

// ==== verilog/ms_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
// Divides the system clock down to a millisecond tick
module ms_tick_gen
    import serial_timing_pkg::*;
#(
    parameter int DIV = CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Tick out
    ms_timer_if.source tmr
);
    // Refuse dividers that the 16-bit count cannot serve
    if (DIV < 2 || DIV > 65536) begin : g_bad_div
        $error("DIV out of range");
    end
    logic [15:0] cnt; // Cycle count within a millisecond

    // Free-running divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0000;
            tmr.tick <= 1'b0;
        end else if (tmr.ce) begin
            if (cnt == 16'(DIV - 1)) begin
                cnt <= 16'h0000;
                tmr.tick <= 1'b1;
            end else begin
                cnt <= cnt + 16'h0001;
                tmr.tick <= 1'b0;
            end
        end
    end
endmodule : ms_tick_gen
`default_nettype wire

// ==== verilog/ms_countdown.sv ====
`timescale 1ns/1ps
`default_nettype none
// Restartable millisecond countdown, flags expiry
module ms_countdown #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Tick
    ms_timer_if.sink tmr,
    // Control
    input wire logic start,
    input wire logic [W-1:0] load_ms,
    // Status
    output logic busy,
    output logic expired
);
    // Refuse a counter with no bits
    if (W < 1) begin : g_bad_w
        $error("W too small");
    end
    logic [W-1:0] left; // Milliseconds remaining

    // Restart on start, count down on ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left <= '0;
            busy <= 1'b0;
            expired <= 1'b0;
        end else if (tmr.ce) begin
            expired <= 1'b0;
            if (start) begin
                left <= load_ms;
                busy <= (load_ms != '0);
                expired <= (load_ms == '0);
            end else if (busy && tmr.tick) begin
                // First tick ends a partial ms, so run one tick more
                if (left == '0) begin
                    busy <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    left <= left - W'(1);
                end
            end
        end
    end
endmodule : ms_countdown
`default_nettype wire

// ==== dv/host_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host end of the link: finishes characters, then answers
module host_link_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Character handshake
    input wire logic tx_char_go,
    input wire logic tx_two_stop,
    input wire logic last_char,
    // Answer: 0 silent, 1 ACK, 2 NAK
    input wire logic [1:0] reply,
    output logic tx_char_done,
    output logic ack_rx,
    output logic nak_rx
);
    int cnt; // Cycles left in the character on the wire
    int rwait; // Cycles until the host answers
    // A second stop bit stretches each character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            rwait <= 0;
            tx_char_done <= 1'b0;
            ack_rx <= 1'b0;
            nak_rx <= 1'b0;
        end else begin
            tx_char_done <= (cnt == 1);
            // Answer a few cycles after the last character
            if (tx_char_done && last_char) rwait <= 8;
            else if (rwait != 0) rwait <= rwait - 1;
            ack_rx <= rwait == 1 && reply == 2'h1;
            nak_rx <= rwait == 1 && reply == 2'h2;
            if (tx_char_go) cnt <= tx_two_stop ? 12 : 10;
            else if (cnt != 0) cnt <= cnt - 1;
        end
    end
endmodule : host_link_model
`default_nettype wire

// ==== dv/host_serial_timing_events_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
`define WAITU(c, n) for (int w = 0; w < (n) && !(c); w++) @(posedge pclk)
// Drives APB, link and events; checks against queue models
module host_serial_timing_events_bench
    import serial_timing_pkg::*;
;
    logic pclk = 0, presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic tx_char_done, tx_char_go, tx_two_stop, ack_rx, nak_rx, pend;
    logic msg_start = 0, msg_raw = 0, host_has_send = 0, event_ready = 0;
    logic [5:0] pin = '0; // Decode, perr, stored, defaults, rx, rx end
    logic rx_discard, resend_req, event_valid, irq;
    logic [7:0] event_code;
    logic [1:0] reply = '0; // Host answer kind
    int error_cnt = 0, checks_done = 0, cyc = 0, left = 0, nmsg = 0;
    int dn = 0, resends = 0, discards = 0, since = 0, en = 4, g, r0;
    int gaps[$], evq[$];
    logic [7:0] codes[4] = '{EV_DECODE, EV_PARAM_ERR, EV_PARAM_STORED,
        EV_DEFAULTS};
    int sa[7] = '{4, 4, 8, 8, 12, 12, 12}; // Setting writes
    int sv[7] = '{200, 99, 100, 99, 0, 100, 1};
    int se[7] = '{0, 99, 20, 99, 25, 25, 1};
    assign pend = (left > 0);
    // Clock
    initial forever #12.5 pclk = ~pclk;
    host_serial_timing_events host_serial_timing_events_i (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_char_done(tx_char_done),
        .tx_char_go(tx_char_go), .tx_two_stop(tx_two_stop),
        .msg_start(msg_start), .msg_raw(msg_raw), .msg_char_pending(pend),
        .ack_rx(ack_rx), .nak_rx(nak_rx), .host_has_send(host_has_send),
        .rx_char(pin[4]), .rx_msg_end(pin[5]), .rx_discard(rx_discard),
        .resend_req(resend_req), .decode_ok(pin[0]), .param_err(pin[1]),
        .param_stored(pin[2]), .defaults_set(pin[3]),
        .event_valid(event_valid), .event_code(event_code),
        .event_ready(event_ready), .irq(irq));
    host_link_model host_link_model_i (
        .pclk(pclk), .presetn(presetn), .tx_char_go(tx_char_go),
        .tx_two_stop(tx_two_stop), .last_char(!pend), .reply(reply),
        .tx_char_done(tx_char_done), .ack_rx(ack_rx), .nak_rx(nak_rx));
    // Monitor: gaps, resends, events, timeout
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        since <= tx_char_done ? 0 : since + 1;
        if (tx_char_go) gaps.push_back(since);
        if (resend_req) left <= nmsg;
        else if (tx_char_go) left <= left - 1;
        dn <= dn + tx_char_done;
        resends <= resends + resend_req;
        discards <= discards + rx_discard;
        event_ready <= 1'($urandom);
        if (event_valid && event_ready) begin
            `CHK(event_code, evq.size() ? evq.pop_front() : 'hFF);
        end
        if (cyc == 100000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
        checks_done++;
        if (gv !== ev) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, gv, ev);
        end
    endtask : chk
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input int d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input int e);
        apb(1'b0, a, 0);
        chk(q, 32'(e));
    endtask : rdc
    // Poll status until a bit reaches its value
    task automatic stbit(input int b, input logic e);
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, OFS_STATUS, 0);
            if (q[b] === e) break;
        end
        chk(32'(q[b]), 32'(e));
    endtask : stbit
    task automatic pulse(input int k);
        @(posedge pclk);
        pin <= 6'(1 << k);
        @(posedge pclk);
        pin <= '0;
    endtask : pulse
    // Event input with expected report
    task automatic fire(input int k);
        if (k == 3) en = en | 4;
        if (k == 0 ? en[0] : en[2]) evq.push_back(codes[k]);
        pulse(k);
        repeat (4) @(posedge pclk);
        `WAITU(evq.size() == 0 && !event_valid, 200);
        `CHK(evq.size(), 0);
    endtask : fire
    task automatic send(input int n, input logic raw, input int lim);
        int d0 = dn;
        @(posedge pclk);
        gaps.delete();
        nmsg = n;
        left <= n;
        msg_raw <= raw;
        msg_start <= 1'b1;
        @(posedge pclk);
        msg_start <= 1'b0;
        `WAITU(dn >= d0 + n, lim);
    endtask : send
    initial begin
        void'($urandom(67084));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFS_CTRL, RST_STOP);
        rdc(OFS_RESP, RST_RESP);
        rdc(OFS_CHAR, RST_CHAR);
        rdc(OFS_EVEN, RST_EVEN);
        rdc(12'h100, 0);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL, i == 0 ? 2 : i == 1 ? 3 : 1);
            repeat (2) @(posedge pclk);
            `CHK(tx_two_stop, i < 2);
        end
        for (int i = 0; i < 7; i++) begin
            wr(12'(sa[i]), sv[i]);
            rdc(12'(sa[i]), se[i]);
        end
        wr(OFS_GAP, 0);
        send(2, 1'b1, 500);
        `CHK(gaps.size(), 2);
        g = gaps[1];
        `CHK(g <= 3, 1);
        wr(OFS_GAP, 1);
        send(2, 1'b1, 90000);
        g = gaps[1];
        `CHK(g >= CYCLES_PER_MS - 2 && g <= 2 * CYCLES_PER_MS + 4, 1);
        wr(OFS_GAP, 0);
        wr(OFS_CTRL, 'h101);
        wr(OFS_RESP, 1);
        reply <= 2'h1;
        r0 = resends;
        send(1, 1'b0, 500);
        stbit(ST_TX_DONE, 1'b1);
        `CHK(resends, r0);
        for (int i = 0; i < 2; i++) begin
            wr(OFS_IRQ_CLR, 'h1F);
            wr(OFS_RESP, 1 - i);
            reply <= i ? 2'h0 : 2'h2;
            r0 = resends;
            send(1, 1'b0, 500);
            `WAITU(resends >= r0 + 2, 2000);
            stbit(ST_TX_ERR, 1'b1);
            `CHK(resends, r0 + 2);
        end
        wr(OFS_IRQ_CLR, 'h1F);
        r0 = resends;
        send(1, 1'b1, 500);
        repeat (50) @(posedge pclk);
        `CHK(resends, r0);
        stbit(ST_TX_ERR, 1'b0);
        host_has_send <= 1'b1;
        send(1, 1'b0, 200);
        stbit(ST_CONTEND_ERR, 1'b1);
        host_has_send <= 1'b0;
        en = 1;
        wr(OFS_EVEN, 1);
        for (int k = 0; k < 3; k++) fire(k);
        en = 0;
        wr(OFS_EVEN, 0);
        for (int k = 0; k < 4; k++) fire(k == 0 ? 0 : 4 - k);
        rdc(OFS_EVEN, 4);
        pulse(4);
        pulse(4);
        pulse(5);
        repeat (10) @(posedge pclk);
        `CHK(discards, 0);
        wr(OFS_IRQ_EN, 0);
        stbit(ST_EVENT_SENT, 1'b1);
        `CHK(irq, 0);
        wr(OFS_IRQ_EN, 'h10);
        stbit(ST_EVENT_SENT, 1'b1);
        `CHK(irq, 1);
        wr(OFS_IRQ_CLR, 'h1F);
        stbit(ST_EVENT_SENT, 1'b0);
        `CHK(irq, 0);
        conclude();
    end
endmodule : host_serial_timing_events_bench
`default_nettype wire
